// ===== rtl/sfd_consts.svh
// Constants for the supply fault detector logic
`ifndef SFD_CONSTS_SVH
`define SFD_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFD_CLK_MHZ     12'h028
`define SFD_TMO_MAX_US  7'h64
`define SFD_TMO_MAX_CYC (12'(`SFD_TMO_MAX_US) * `SFD_CLK_MHZ)

// ----------------------------------------------------------------
// Range codes, bottoms and spans in mV
// ----------------------------------------------------------------
`define SFD_RNG_0   2'h0
`define SFD_RNG_1   2'h1
`define SFD_RNG_2   2'h2
`define SFD_RNG_3   2'h3
`define SFD_BOT_0   14'h023d
`define SFD_BOT_1   14'h04e2
`define SFD_BOT_2   14'h09c4
`define SFD_BOT_3   14'h1770
`define SFD_SPN_0   14'h0322
`define SFD_SPN_1   14'h06d6
`define SFD_SPN_2   14'h0dac
`define SFD_SPN_3   14'h20d0
`define SFD_CODE_DIV 22'h0000ff

// ----------------------------------------------------------------
// Channel map
// ----------------------------------------------------------------
`define SFD_NCH      8
`define SFD_NDUAL    4
`define SFD_DUAL_LO  4

`endif

// ===== rtl/sfd_pkg.sv
// Types for the supply fault detector logic
package sfd_pkg;

	typedef enum logic [1:0] {
		SFD_FT_UV  = 2'b00,
		SFD_FT_OV  = 2'b01,
		SFD_FT_WIN = 2'b10
	} sfd_ftype_e;

	typedef enum logic [1:0] {
		SFD_K_HV   = 2'b00,
		SFD_K_POS  = 2'b01,
		SFD_K_DUAL = 2'b10
	} sfd_kind_e;

	typedef struct packed {
		logic [7:0] uv_th;
		logic [7:0] ov_th;
		logic [4:0] hysteresis_code;
		logic [1:0] range_sel;
		sfd_ftype_e ftype;
		logic [6:0] tmo_us;
		logic       logic_mode;
	} sfd_cfg_s;

	typedef struct packed {
		logic        uv;
		logic        ov;
		logic [1:0]  range_eff;
		logic [15:0] uv_mv;
		logic [15:0] ov_mv;
		logic [15:0] hyst_mv;
	} sfd_stat_s;

endpackage

// ===== rtl/sfd_detector.sv
// Eight-channel supply fault detector with hysteresis and glitch filter
`timescale 1ns/10ps
`include "sfd_consts.svh"

// ----------------------------------------------------------------
// One detector channel
// ----------------------------------------------------------------
module sfd_chan #(
	parameter sfd_pkg::sfd_kind_e KIND = sfd_pkg::SFD_K_POS
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire sfd_pkg::sfd_cfg_s cfg,
	input  wire logic [7:0]        code,
	input  wire logic              logic_in,
	output logic                   flt_r,
	output sfd_pkg::sfd_stat_s     stat_r
);
	logic        uv_r;
	logic        ov_r;
	logic        raw_r;
	logic [11:0] cnt_r;
	logic [11:0] tgt_r;
	logic [1:0]  rng_nxt;
	logic        dig;
	logic [8:0]  uv_rel;
	logic [8:0]  ov_rel;

	function automatic logic [15:0] scale_mv(input logic [1:0] rng, input logic [7:0] n);
		logic [13:0] bot;
		logic [13:0] spn;
		logic [21:0] prod;
		unique case (rng)
			`SFD_RNG_0: begin bot = `SFD_BOT_0; spn = `SFD_SPN_0; end
			`SFD_RNG_1: begin bot = `SFD_BOT_1; spn = `SFD_SPN_1; end
			`SFD_RNG_2: begin bot = `SFD_BOT_2; spn = `SFD_SPN_2; end
			default:    begin bot = `SFD_BOT_3; spn = `SFD_SPN_3; end
		endcase
		prod = 22'(spn) * 22'(n);
		scale_mv = 16'(bot) + 16'(prod / `SFD_CODE_DIV);
	endfunction

	assign dig    = (KIND == sfd_pkg::SFD_K_DUAL) && cfg.logic_mode;
	assign uv_rel = {1'b0, cfg.uv_th} + 9'(cfg.hysteresis_code);
	assign ov_rel = {1'b0, code} + 9'(cfg.hysteresis_code);

	// Legal range per channel kind
	always_comb begin
		unique case (KIND)
			sfd_pkg::SFD_K_HV:  rng_nxt = cfg.range_sel[1] ? cfg.range_sel : `SFD_RNG_2;
			sfd_pkg::SFD_K_POS: rng_nxt = (cfg.range_sel == `SFD_RNG_3) ? `SFD_RNG_2 : cfg.range_sel;
			default:            rng_nxt = `SFD_RNG_0;
		endcase
	end

	// ----------------------------------------------------------------
	// Comparators with hysteresis, held clear in logic mode
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset || dig) begin
			uv_r <= 1'b0;
		end else if (!uv_r) begin
			uv_r <= code < cfg.uv_th;
		end else begin
			uv_r <= {1'b0, code} <= uv_rel;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || dig) begin
			ov_r <= 1'b0;
		end else if (!ov_r) begin
			ov_r <= code > cfg.ov_th;
		end else begin
			ov_r <= ov_rel >= {1'b0, cfg.ov_th};
		end
	end

	// Fault type selection or logic input
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			raw_r <= 1'b0;
		end else if (dig) begin
			raw_r <= logic_in;
		end else begin
			unique case (cfg.ftype)
				sfd_pkg::SFD_FT_UV:  raw_r <= uv_r;
				sfd_pkg::SFD_FT_OV:  raw_r <= ov_r;
				sfd_pkg::SFD_FT_WIN: raw_r <= uv_r | ov_r;
				default:             raw_r <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Glitch filter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tgt_r <= 12'h000;
		end else if (cfg.tmo_us > `SFD_TMO_MAX_US) begin
			tgt_r <= `SFD_TMO_MAX_CYC;
		end else begin
			tgt_r <= 12'(cfg.tmo_us) * `SFD_CLK_MHZ;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_r <= 12'h000;
			flt_r <= 1'b0;
		end else if (raw_r == flt_r) begin
			cnt_r <= 12'h000;
		end else if (cnt_r >= tgt_r) begin
			cnt_r <= 12'h000;
			flt_r <= raw_r;
		end else begin
			cnt_r <= cnt_r + 12'h001;
		end
	end

	// Status readback
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stat_r <= '0;
		end else begin
			stat_r.uv        <= uv_r;
			stat_r.ov        <= ov_r;
			stat_r.range_eff <= rng_nxt;
			stat_r.uv_mv     <= scale_mv(rng_nxt, cfg.uv_th);
			stat_r.ov_mv     <= scale_mv(rng_nxt, cfg.ov_th);
			stat_r.hyst_mv   <= scale_mv(rng_nxt, 8'(cfg.hysteresis_code))
				- scale_mv(rng_nxt, 8'h00);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence flt_pending;
		raw_r != flt_r && cnt_r < tgt_r;
	endsequence

	sequence flt_expired;
		raw_r != flt_r && cnt_r >= tgt_r;
	endsequence

	// Comparator and fault type checks
	uv_set_a: assert property (!dig && !uv_r && code < cfg.uv_th |=> uv_r)
		else $error("Undervoltage not flagged");
	uv_hyst_a: assert property (!dig && uv_r && {1'b0, code} <= uv_rel |=> uv_r)
		else $error("Undervoltage cleared inside hysteresis");
	ov_hyst_a: assert property (!dig && ov_r && ov_rel >= {1'b0, cfg.ov_th} |=> ov_r)
		else $error("Overvoltage cleared inside hysteresis");
	ov_set_a: assert property (!dig && !ov_r && code > cfg.ov_th |=> ov_r)
		else $error("Overvoltage not flagged");
	uv_clr_a: assert property (!dig && uv_r && {1'b0, code} > uv_rel |=> !uv_r)
		else $error("Undervoltage held above hysteresis");
	ov_clr_a: assert property (!dig && ov_r && ov_rel < {1'b0, cfg.ov_th} |=> !ov_r)
		else $error("Overvoltage held below hysteresis");
	uv_sel_a: assert property (!dig && cfg.ftype == sfd_pkg::SFD_FT_UV |=> raw_r == $past(uv_r))
		else $error("Undervoltage type not selected");
	ov_sel_a: assert property (!dig && cfg.ftype == sfd_pkg::SFD_FT_OV |=> raw_r == $past(ov_r))
		else $error("Overvoltage type not selected");
	raw_none_a: assert property (!dig && cfg.ftype == 2'b11 |=> !raw_r)
		else $error("Unused fault type raised a fault");
	win_sel_a: assert property (!dig && cfg.ftype == sfd_pkg::SFD_FT_WIN |=> raw_r == $past(uv_r | ov_r))
		else $error("Window fault not the union of both");
	// Filter, range, logic mode and status checks
	flt_block_a: assert property (flt_pending |=> $stable(flt_r))
		else $error("Filter passed a short pulse");
	flt_pass_a: assert property (flt_expired |=> flt_r == $past(raw_r))
		else $error("Filter did not pass after timeout");
	flt_count_a: assert property ($changed(flt_r) |-> $past(cnt_r) == $past(tgt_r))
		else $error("Filter changed before full count");
	tmo_max_a: assert property (tgt_r <= `SFD_TMO_MAX_CYC)
		else $error("Timeout above maximum");
	dual_rng_a: assert property (KIND == sfd_pkg::SFD_K_DUAL |=> stat_r.range_eff == `SFD_RNG_0)
		else $error("Dual-purpose channel not in lowest range");
	logic_sel_a: assert property (dig |=> raw_r == $past(logic_in) && !uv_r && !ov_r)
		else $error("Logic mode not routed through filter");
	flt_hold_a: assert property (raw_r == flt_r |=> $stable(flt_r))
		else $error("Filter output moved without input change");
	cnt_clr_a: assert property (raw_r == flt_r |=> cnt_r == 12'h000)
		else $error("Filter count not cleared");
	stat_flag_a: assert property (1 |=> {stat_r.uv, stat_r.ov} == $past({uv_r, ov_r}))
		else $error("Status flags not updated");
endmodule

// ----------------------------------------------------------------
// Top: channel 0 high voltage, 1-3 positive, 4-7 dual-purpose
// ----------------------------------------------------------------
module sfd_detector #(
	parameter int NCH = `SFD_NCH
) (
	input  wire logic                         clk_sys,
	input  wire logic                         reset,
	input  wire sfd_pkg::sfd_cfg_s [NCH-1:0]  cfg,
	input  wire logic [NCH-1:0][7:0]          code,
	input  wire logic [`SFD_NDUAL-1:0]        logic_in,
	output logic [NCH-1:0]                    fault_r,
	output sfd_pkg::sfd_stat_s [NCH-1:0]      stat_r
);
	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			localparam sfd_pkg::sfd_kind_e K = (i == 0) ? sfd_pkg::SFD_K_HV :
				(i < `SFD_DUAL_LO) ? sfd_pkg::SFD_K_POS : sfd_pkg::SFD_K_DUAL;
			localparam int LI = (i >= `SFD_DUAL_LO) ? i - `SFD_DUAL_LO : 0;
			sfd_chan #(.KIND(K)) i_sfd_chan (
				.clk_sys  (clk_sys),
				.reset    (reset),
				.cfg      (cfg[i]),
				.code     (code[i]),
				.logic_in ((i >= `SFD_DUAL_LO) ? logic_in[LI] : 1'b0),
				.flt_r    (fault_r[i]),
				.stat_r   (stat_r[i])
			);
		end
	endgenerate
endmodule

// ===== sim/sfd_rail_model.sv
// Sampling model of the monitored supply rails
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Converter latches each rail once a clock
// ----------------------------------------------------------------
module sfd_rail_model (
	input  wire logic            clk_sys,
	input  wire logic [7:0][7:0] rail,
	output logic      [7:0][7:0] code
);
	always_ff @(posedge clk_sys) begin
		code <= rail;
	end
endmodule

// ===== sim/test_sfd_detector.sv
// Self-checking bench for the supply fault detector
`timescale 1ns/10ps
module test_sfd_detector;
	logic                     clk_sys  = 1'b0;
	logic                     reset    = 1'b1;
	sfd_pkg::sfd_cfg_s [7:0]  cfg;
	logic [7:0][7:0]          rail;
	logic [7:0][7:0]          code;
	logic [3:0]               logic_in = 4'h0;
	logic [7:0]               fault_r;
	sfd_pkg::sfd_stat_s [7:0] stat_r;
	int                       fails    = 0;
	int                       compares = 0;

	always #12.5 clk_sys = ~clk_sys;

	sfd_rail_model i_sfd_rail_model (.clk_sys(clk_sys), .rail(rail), .code(code));
	sfd_detector i_sfd_detector (.clk_sys(clk_sys), .reset(reset), .cfg(cfg), .code(code),
		.logic_in(logic_in), .fault_r(fault_r), .stat_r(stat_r));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic set_rail(input int ch, input logic [7:0] v);
		@(posedge clk_sys);
		rail[ch] <= v;
	endtask

	task automatic expect_at(input int n, input int ch, input logic e);
		repeat (n) @(posedge clk_sys);
		#1;
		chk(fault_r[ch], e);
	endtask

	task automatic report_and_stop();
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		#1;
		chk(fault_r, 8'h00);
		chk(stat_r[0].range_eff, 2'h2);
		chk(stat_r[4].range_eff, 2'h0);
		chk(stat_r[1].uv_mv, 16'h0306);
		chk(stat_r[1].ov_mv, 16'h0498);
		chk(stat_r[1].hyst_mv, 16'h000c);
		chk(stat_r[0].uv_mv, 16'h0d32);
	endtask

	task automatic t_ov_hyst();
		@(posedge clk_sys);
		cfg[0].ftype <= sfd_pkg::SFD_FT_OV;
		set_rail(0, 8'hc1);
		expect_at(3, 0, 1'b0);
		expect_at(1, 0, 1'b1);
		set_rail(0, 8'hbc);
		expect_at(8, 0, 1'b1);
		set_rail(0, 8'hbb);
		expect_at(3, 0, 1'b1);
		expect_at(1, 0, 1'b0);
	endtask

	task automatic t_ranges();
		@(posedge clk_sys);
		cfg[0].range_sel <= 2'h3;
		cfg[1].range_sel <= 2'h3;
		cfg[4].range_sel <= 2'h3;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(stat_r[0].range_eff, 2'h3);
		chk(stat_r[1].range_eff, 2'h2);
		chk(stat_r[4].range_eff, 2'h0);
		chk(stat_r[0].uv_mv, 16'h1fac);
		chk(stat_r[0].hyst_mv, 16'h0083);
		chk(stat_r[1].ov_mv, 16'h140f);
	endtask

	task automatic t_uv_hyst();
		set_rail(1, 8'h3f);
		expect_at(3, 1, 1'b0);
		expect_at(1, 1, 1'b1);
		set_rail(1, 8'h44);
		expect_at(8, 1, 1'b1);
		set_rail(1, 8'h45);
		expect_at(3, 1, 1'b1);
		expect_at(1, 1, 1'b0);
	endtask

	task automatic t_types();
		for (int f = 0; f < 4; f++) begin
			@(posedge clk_sys);
			cfg[2].ftype <= sfd_pkg::sfd_ftype_e'(f);
			set_rail(2, 8'hc1);
			expect_at(4, 2, f == 1 || f == 2);
			chk(stat_r[2].ov, 1'b1);
			set_rail(2, 8'h3f);
			expect_at(4, 2, f == 0 || f == 2);
			chk(stat_r[2].uv, 1'b1);
			set_rail(2, 8'h80);
			expect_at(6, 2, 1'b0);
		end
	endtask

	task automatic t_filter();
		@(posedge clk_sys);
		cfg[3].tmo_us <= 7'h01;
		set_rail(3, 8'h3f);
		expect_at(19, 3, 1'b0);
		set_rail(3, 8'h80);
		expect_at(60, 3, 1'b0);
		set_rail(3, 8'h3f);
		expect_at(43, 3, 1'b0);
		expect_at(1, 3, 1'b1);
		set_rail(3, 8'h80);
		expect_at(43, 3, 1'b1);
		expect_at(1, 3, 1'b0);
		@(posedge clk_sys);
		cfg[3].tmo_us <= 7'h7f;
		set_rail(3, 8'h3f);
		expect_at(4003, 3, 1'b0);
		expect_at(1, 3, 1'b1);
	endtask

	task automatic t_logic();
		@(posedge clk_sys);
		cfg[4].logic_mode <= 1'b1;
		cfg[7].logic_mode <= 1'b1;
		set_rail(4, 8'h00);
		expect_at(8, 4, 1'b0);
		@(posedge clk_sys);
		logic_in <= 4'h9;
		expect_at(1, 4, 1'b0);
		expect_at(1, 4, 1'b1);
		chk(fault_r[7], 1'b1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		for (int i = 0; i < 8; i++) begin
			cfg[i] <= '{8'h40, 8'hc0, 5'h04, 2'h0, sfd_pkg::SFD_FT_UV, 7'h00, 1'b0};
			rail[i] <= 8'h80;
		end
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_uv_hyst();
		t_ov_hyst();
		t_types();
		t_ranges();
		t_logic();
		t_filter();
		report_and_stop();
	end

	initial begin
		#250000;
		fails++;
		report_and_stop();
	end
endmodule
